/* File: bench/ebi_mem_model.sv */
// bus responder: ends each data strobe after a set wait with a set port width ack, or a bus fault when set
`timescale 1ns/100ps
`default_nettype none
module ebi_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus from the device
    input wire logic address_strobe,
    input wire logic data_strobe,
    input wire logic read_not_write,
    // behaviour set by the bench
    input wire logic [1:0] cfg_port,
    input wire logic [1:0] cfg_wait,
    input wire logic cfg_fault,
    // responses
    output logic [31:0] data_in,
    output logic [1:0] port_width_ack,
    output logic bus_fault_input
);
    logic [1:0] wait_q;
    logic done_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 2'h0;
            done_q <= 1'b0;
            port_width_ack <= ebi_pkg::ACK_NONE;
            bus_fault_input <= 1'b0;
        end else if (!address_strobe) begin
            wait_q <= 2'h0;
            done_q <= 1'b0;
            port_width_ack <= ebi_pkg::ACK_NONE;
            bus_fault_input <= 1'b0;
        end else if (data_strobe && !done_q) begin
            if (wait_q == cfg_wait) begin
                done_q <= 1'b1;
                port_width_ack <= cfg_fault ? ebi_pkg::ACK_NONE : cfg_port;
                bus_fault_input <= cfg_fault;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end

    // read data held while acked, otherwise undriven lines keep changing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_in <= 32'h0;
        end else if (data_strobe && read_not_write && !done_q && wait_q == cfg_wait) begin
            data_in <= {data_in[15:0], ~data_in[31:16]} ^ 32'h5a3c_96e1;
        end else if (!(done_q && read_not_write)) begin
            data_in <= ~data_in;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the external bus engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk, rstn, op_valid, op_write, op_locked, op_ready, op_done, op_fault;
    logic [31:0] op_addr, op_wdata, op_rdata, addr, data_in, data_out;
    logic [2:0] op_space, op_bytes, space_code, irq_level_inputs, irq_mask, irq_level;
    logic [1:0] bytes_left_lines, port_width_ack, cfg_port, cfg_wait;
    logic locked_cycle_flag, cycle_begin_pulse, first_operand_cycle_pulse, address_strobe;
    logic data_strobe, read_not_write, buffer_enable, data_oe, bus_fault_input, halt_input;
    logic cache_off_input, cache_enable, auto_vector_request, irq_waiting_output;
    logic irq_autovector, bus_request, grant_acknowledge, bus_grant, cfg_fault;
    int fail_count, num_checks, cycles;
    // one entry per bus cycle: addr, bytes left, space, read, locked, first
    logic [39:0] seen_q[$];
    logic [39:0] exp_q[$];
    // per bus cycle: lanes driven at start, lanes answered at first ack
    logic [31:0] wd_q[$];
    logic [31:0] rd_q[$];
    logic got_ack = 1'b1;

    ebi_core dut (.clk, .rstn, .op_valid, .op_addr, .op_space, .op_bytes, .op_write,
        .op_locked, .op_wdata, .op_ready, .op_done, .op_fault, .op_rdata, .addr,
        .space_code, .bytes_left_lines, .locked_cycle_flag, .cycle_begin_pulse,
        .first_operand_cycle_pulse, .address_strobe, .data_strobe, .read_not_write,
        .buffer_enable, .data_in, .data_out, .data_oe, .port_width_ack, .bus_fault_input,
        .halt_input, .cache_off_input, .cache_enable, .irq_level_inputs, .irq_mask,
        .auto_vector_request, .irq_waiting_output, .irq_level, .irq_autovector,
        .bus_request, .grant_acknowledge, .bus_grant);

    ebi_mem_model mem (.clk, .rstn, .address_strobe, .data_strobe, .read_not_write,
        .cfg_port, .cfg_wait, .cfg_fault, .data_in, .port_width_ack, .bus_fault_input);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (cycle_begin_pulse === 1'b1) begin
            seen_q.push_back({addr, bytes_left_lines, space_code, read_not_write,
                locked_cycle_flag, first_operand_cycle_pulse});
            wd_q.push_back(data_out);
            got_ack = 1'b0;
        end
        if (port_width_ack !== ebi_pkg::ACK_NONE && !got_ack) begin
            rd_q.push_back(data_in);
            got_ack = 1'b1;
        end
        if (data_strobe === 1'b1) begin
            check(address_strobe === 1'b1 && buffer_enable === 1'b1, "strobes");
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // one operand through the bus, checked cycle by cycle against the sizing model
    task automatic run_op(input logic [31:0] a, input int n, input logic w, input logic lk,
            input logic [2:0] sp, input logic [1:0] pc, input logic flt);
        int left, cap, p, k, off;
        logic [31:0] cur, wd, rexp;
        exp_q.delete();
        seen_q.delete();
        wd_q.delete();
        rd_q.delete();
        p = (pc == 2'h3) ? 4 : int'(pc);
        cur = a;
        left = n;
        while (left > 0) begin
            cap = p - (int'(cur[1:0]) % p);
            exp_q.push_back({cur, 2'(left), sp, ~w, lk, 1'(left == n)});
            if (cap > left) begin
                cap = left;
            end
            cur = cur + 32'(cap);
            left = flt ? 0 : left - cap;
        end
        @(posedge clk);
        cfg_port <= pc;
        cfg_fault <= flt;
        cfg_wait <= 2'($urandom_range(3));
        op_valid <= 1'b1;
        op_addr <= a;
        op_bytes <= 3'(n);
        op_write <= w;
        op_locked <= lk;
        op_space <= sp;
        wd = $urandom;
        op_wdata <= wd;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (op_ready !== 1'b1 && k < 100);
        @(posedge clk);
        op_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (op_done !== 1'b1 && k < 300);
        check(op_done === 1'b1, "operand not done");
        check(op_fault === flt, "fault flag");
        check(seen_q.size() == exp_q.size(), "bus cycle count");
        for (int i = 0; i < exp_q.size() && i < seen_q.size(); i++) begin
            check(seen_q[i] === exp_q[i], "bus cycle fields");
        end
        cur = a;
        off = 0;
        rexp = 32'h0;
        for (int i = 0; i < exp_q.size() && i < wd_q.size() && i < rd_q.size(); i++) begin
            cap = p - (int'(cur[1:0]) % p);
            if (cap > n - off) begin
                cap = n - off;
            end
            for (int j = 0; j < cap; j++) begin
                if (w) begin
                    check(wd_q[i][8*(int'(cur[1:0])+j) +: 8] === wd[8*(off+j) +: 8], "write lane");
                end
                rexp[8*(off+j) +: 8] = rd_q[i][8*(int'(cur[1:0])+j) +: 8];
            end
            cur = cur + 32'(cap);
            off += cap;
        end
        if (!w && !flt) begin
            check(op_rdata === rexp, "read data");
        end
    endtask

    initial begin
        int k;
        logic [2:0] m;
        logic av;
        rstn = 1'b0;
        {op_valid, op_write, op_locked, halt_input, cache_off_input} = 5'h0;
        {auto_vector_request, bus_request, grant_acknowledge, cfg_fault} = 4'h0;
        op_addr = 32'h0;
        op_wdata = 32'h0;
        {op_space, op_bytes, irq_level_inputs, irq_mask} = 12'h0;
        cfg_port = 2'h3;
        cfg_wait = 2'h0;
        void'($urandom(3861));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        run_op(32'hffff_fffc, 4, 1'b0, 1'b0, 3'h5, 2'h3, 1'b0);
        for (int i = 0; i < 24; i++) begin
            run_op($urandom, int'($urandom_range(4, 1)), 1'($urandom), 1'b0,
                3'($urandom), 2'($urandom_range(3, 1)), 1'b0);
        end
        run_op(32'h0000_2003, 2, 1'b0, 1'b1, 3'h1, 2'h1, 1'b0);
        run_op(32'h0000_2003, 2, 1'b1, 1'b1, 3'h1, 2'h1, 1'b0);
        run_op(32'h0000_1002, 4, 1'b0, 1'b0, 3'h2, 2'h2, 1'b1);
        @(posedge clk);
        halt_input <= 1'b1;
        repeat (4) @(posedge clk);
        repeat (12) begin
            @(negedge clk);
            check(op_ready !== 1'b1 && cycle_begin_pulse !== 1'b1, "bus while halted");
        end
        @(posedge clk);
        halt_input <= 1'b0;
        run_op(32'h0000_0041, 3, 1'b1, 1'b0, 3'h6, 2'h3, 1'b0);
        @(posedge clk);
        bus_request <= 1'b1;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (bus_grant !== 1'b1 && k < 20);
        check(k - 1 >= int'(ebi_pkg::GRANT_DLY) && k - 1 <= int'(ebi_pkg::GRANT_MAX), "grant");
        @(posedge clk);
        grant_acknowledge <= 1'b1;
        bus_request <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (bus_grant !== 1'b0 && k < 20);
        check(k - 1 >= int'(ebi_pkg::RELEASE_DLY) && k - 1 <= int'(ebi_pkg::GRANT_MAX), "ungrant");
        repeat (8) begin
            @(negedge clk);
            check(op_ready !== 1'b1, "accept while bus given away");
        end
        @(posedge clk);
        grant_acknowledge <= 1'b0;
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            cache_off_input <= 1'(v);
            repeat (6) @(negedge clk);
            check(cache_enable === 1'(1 - v), "cache enable");
        end
        for (int lv = 0; lv < 8; lv++) begin
            @(posedge clk);
            m = 3'($urandom);
            irq_level_inputs <= 3'(lv);
            irq_mask <= m;
            av = 1'($urandom);
            auto_vector_request <= av;
            repeat (6) @(negedge clk);
            check(irq_waiting_output === 1'(lv > int'(m) || lv == 7), "irq pending");
            check(irq_level === 3'(lv) && irq_autovector === av, "irq inputs");
        end
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: hdl/ebi_arbiter.sv */
// three wire bus arbitration toward an alternate master
`timescale 1ns/100ps
`default_nettype none
module ebi_arbiter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised pins and core bus state
    input wire logic bus_request,
    input wire logic grant_acknowledge,
    input wire logic locked,
    input wire logic bus_idle,
    // outputs
    output logic bus_grant,
    output logic bus_owned
);
    ebi_pkg::ebi_arb_t st_q;

    // two synchroniser stages plus this edge already span three clocks,
    // inside both the grant and the release windows, so no extra wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ebi_pkg::AR_OWN;
            bus_grant <= 1'b0;
        end else begin
            unique case (st_q)
                ebi_pkg::AR_OWN: begin
                    if (bus_request && !locked) begin
                        bus_grant <= 1'b1; // R18
                        st_q <= ebi_pkg::AR_GRANT;
                    end else if (bus_request) begin
                        st_q <= ebi_pkg::AR_WAIT;
                    end
                end
                // request held off by a locked sequence
                ebi_pkg::AR_WAIT: begin
                    if (!bus_request) begin
                        st_q <= ebi_pkg::AR_OWN;
                    end else if (!locked) begin
                        bus_grant <= 1'b1; // R18
                        st_q <= ebi_pkg::AR_GRANT;
                    end
                end
                ebi_pkg::AR_GRANT: begin
                    if (grant_acknowledge) begin
                        bus_grant <= 1'b0; // R19
                        st_q <= ebi_pkg::AR_OFF;
                    end else if (!bus_request) begin
                        bus_grant <= 1'b0;
                        st_q <= ebi_pkg::AR_OWN;
                    end
                end
                ebi_pkg::AR_OFF: begin
                    if (!grant_acknowledge) begin
                        st_q <= ebi_pkg::AR_OWN; // R17
                    end
                end
            endcase
        end
    end

    assign bus_owned = (st_q == ebi_pkg::AR_OFF) || grant_acknowledge;
endmodule
`default_nettype wire

/* File: hdl/ebi_core.sv */
// external bus cycle engine with arbitration, interrupt and cache-off control
// Overview of operation
// R1: drive full 32-bit byte address
// R2: move 8 to 32 bits per cycle
// R3: drive 3-bit address space code
// R4: bytes left lines select lanes with A1:A0
// R5: flag every locked read-modify-write cycle
// R6: pulse cycle begin at each cycle
// R7: pulse operand start on first cycle only
// R8: address strobe only while address valid; addr advances at the ack, one clock before address_strobe drops
// R9: data strobe marks the data phase
// R10: drive read or write direction line
// R11: enable data buffers during data phase
// R12: responder ends cycle with port width ack
// R13: cache off while cache off input asserted
// R14: interrupt logic presents encoded level
// R15: autovector may replace supplied vector
// R16: flag recognised pending interrupt
// R17: request, grant, grant acknowledge handshake
// R18: grant 1.5 to 3.5 clocks after request; held off until a locked sequence ends
// R19: drop grant 1.5 to 3.5 after acknowledge
// R20: master drops request soon after acknowledge
// R21: bus fault input ends invalid cycle
// R22: halt input suspends bus activity
`timescale 1ns/100ps
`default_nettype none
module ebi_core (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // core operand request
    input wire logic op_valid,
    input wire logic [31:0] op_addr,
    input wire logic [2:0] op_space,
    input wire logic [2:0] op_bytes,
    input wire logic op_write,
    input wire logic op_locked,
    input wire logic [31:0] op_wdata,
    output logic op_ready,
    output logic op_done,
    output logic op_fault,
    output logic [31:0] op_rdata,
    // address and control outputs
    output logic [31:0] addr,
    output logic [2:0] space_code,
    output logic [1:0] bytes_left_lines,
    output logic locked_cycle_flag,
    output logic cycle_begin_pulse,
    output logic first_operand_cycle_pulse,
    output logic address_strobe,
    output logic data_strobe,
    output logic read_not_write,
    output logic buffer_enable,
    // data bus pins
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe,
    // cycle termination
    input wire logic [1:0] port_width_ack,
    input wire logic bus_fault_input,
    input wire logic halt_input,
    // cache and interrupts
    input wire logic cache_off_input,
    output logic cache_enable,
    input wire logic [2:0] irq_level_inputs,
    input wire logic [2:0] irq_mask,
    input wire logic auto_vector_request,
    output logic irq_waiting_output,
    output logic [2:0] irq_level,
    output logic irq_autovector,
    // arbitration
    input wire logic bus_request,
    input wire logic grant_acknowledge,
    output logic bus_grant
);
    logic rst_m_q, rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // two-stage synchronisers for pins
    localparam int unsigned SW = 11;
    logic [SW-1:0] s1_q, s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {port_width_ack, bus_fault_input, halt_input, cache_off_input,
                irq_level_inputs, auto_vector_request, bus_request, grant_acknowledge};
            s2_q <= s1_q;
        end
    end
    logic [1:0] ack_s;
    logic fault_s, halt_s, cache_off_input_s, auto_vector_request_s, br_s, grant_acknowledge_s;
    logic [2:0] ipl_s;
    assign ack_s = s2_q[10:9];
    assign fault_s = s2_q[8];
    assign halt_s = s2_q[7];
    assign cache_off_input_s = s2_q[6];
    assign ipl_s = s2_q[5:3];
    assign auto_vector_request_s = s2_q[2];
    assign br_s = s2_q[1];
    assign grant_acknowledge_s = s2_q[0];

    // bytes moved per cycle for a port width and address offset
    function automatic logic [2:0] moved(input logic [1:0] ack, input logic [1:0] a,
            input logic [2:0] left);
        logic [2:0] cap;
        cap = 3'h4;
        unique case (ack)
            ebi_pkg::ACK_8: cap = 3'h1;
            ebi_pkg::ACK_16: cap = 3'h2 - {2'h0, a[0]};
            default: cap = 3'h4 - {1'b0, a};
        endcase
        moved = (left < cap) ? left : cap;
    endfunction

    // bytes moved this cycle, taken from the lanes at the current address
    function automatic logic [31:0] lanes(input logic [31:0] d, input logic [1:0] a,
            input logic [2:0] n);
        lanes = (d >> {a, 3'h0}) & ~(32'hffff_ffff << {n, 3'h0});
    endfunction

    logic bus_owned;
    ebi_pkg::ebi_bus_t st_q;
    logic [31:0] acc_q;
    logic [2:0] left_q;
    logic [2:0] off_q;
    logic [31:0] wbuf_q;
    logic first_q, lock_q;

    // bus cycle sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ebi_pkg::ST_IDLE;
            addr <= 32'h0;
            space_code <= ebi_pkg::SPACE_RESET;
            bytes_left_lines <= ebi_pkg::SZ_4;
            left_q <= 3'h0;
            off_q <= 3'h0;
            wbuf_q <= 32'h0;
            acc_q <= 32'h0;
            first_q <= 1'b0;
            lock_q <= 1'b0;
            locked_cycle_flag <= 1'b0;
            cycle_begin_pulse <= 1'b0;
            first_operand_cycle_pulse <= 1'b0;
            address_strobe <= 1'b0;
            data_strobe <= 1'b0;
            read_not_write <= 1'b1;
            buffer_enable <= 1'b0;
            data_out <= 32'h0;
            data_oe <= 1'b0;
            op_ready <= 1'b0;
            op_done <= 1'b0;
            op_fault <= 1'b0;
            op_rdata <= 32'h0;
        end else begin
            cycle_begin_pulse <= 1'b0;
            first_operand_cycle_pulse <= 1'b0;
            op_done <= 1'b0;
            op_fault <= 1'b0;
            op_ready <= 1'b0;
            unique case (st_q)
                ebi_pkg::ST_IDLE: begin
                    if (left_q == 3'h0 && !lock_q) begin
                        op_ready <= !halt_s && !bus_owned;
                    end
                    if (op_valid && op_ready && left_q == 3'h0) begin
                        left_q <= (op_bytes == 3'h0 || op_bytes > 3'h4) ? 3'h4 : op_bytes;
                        wbuf_q <= op_wdata;
                        addr <= op_addr; // R1
                        space_code <= op_space; // R3
                        read_not_write <= !op_write; // R10
                        lock_q <= op_locked;
                        first_q <= 1'b1;
                        acc_q <= 32'h0;
                        off_q <= 3'h0;
                        op_ready <= 1'b0;
                    end else if (left_q != 3'h0 && !halt_s && !bus_owned) begin // R22
                        bytes_left_lines <= left_q[1:0]; // R4
                        locked_cycle_flag <= lock_q; // R5
                        cycle_begin_pulse <= 1'b1; // R6
                        first_operand_cycle_pulse <= first_q; // R7
                        first_q <= 1'b0;
                        address_strobe <= 1'b1; // R8
                        data_out <= wbuf_q << {addr[1:0], 3'h0}; // R4
                        data_oe <= !read_not_write;
                        st_q <= ebi_pkg::ST_ADDR;
                    end else if (left_q == 3'h0 && lock_q && !op_valid) begin
                        lock_q <= 1'b0;
                        locked_cycle_flag <= 1'b0;
                    end else if (left_q == 3'h0 && lock_q && op_valid) begin
                        op_ready <= !halt_s;
                    end
                end
                ebi_pkg::ST_ADDR: begin
                    data_strobe <= 1'b1; // R9
                    buffer_enable <= 1'b1; // R11
                    st_q <= ebi_pkg::ST_DATA;
                end
                ebi_pkg::ST_DATA: begin
                    if (fault_s) begin // R21
                        op_fault <= 1'b1;
                        op_done <= 1'b1;
                        left_q <= 3'h0;
                        lock_q <= 1'b0;
                        st_q <= ebi_pkg::ST_DONE;
                    end else if (ack_s != ebi_pkg::ACK_NONE) begin // R12
                        logic [2:0] n;
                        logic [31:0] acc;
                        n = moved(ack_s, addr[1:0], left_q); // R2
                        acc = acc_q | (lanes(data_in, addr[1:0], n) << {off_q[1:0], 3'h0});
                        acc_q <= acc;
                        off_q <= off_q + n;
                        wbuf_q <= wbuf_q >> {n, 3'h0};
                        left_q <= left_q - n;
                        addr <= addr + {29'h0, n};
                        if (left_q == n) begin
                            op_done <= 1'b1;
                            op_rdata <= acc;
                        end
                        st_q <= ebi_pkg::ST_DONE;
                    end
                end
                ebi_pkg::ST_DONE: begin
                    address_strobe <= 1'b0;
                    data_strobe <= 1'b0;
                    buffer_enable <= 1'b0;
                    data_oe <= 1'b0;
                    if (left_q == 3'h0 && !lock_q) begin
                        locked_cycle_flag <= 1'b0;
                    end
                    if (ack_s == ebi_pkg::ACK_NONE && !fault_s) begin
                        st_q <= ebi_pkg::ST_IDLE;
                    end
                end
                default: st_q <= ebi_pkg::ST_IDLE;
            endcase
        end
    end

    // cache disable follows the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_enable <= 1'b0;
        end else begin
            cache_enable <= !cache_off_input_s; // R13
        end
    end

    // interrupt recognition; level 7 is never masked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_waiting_output <= 1'b0;
            irq_level <= 3'h0;
            irq_autovector <= 1'b0;
        end else begin
            irq_level <= ipl_s; // R14
            irq_waiting_output <= (ipl_s > irq_mask) || (ipl_s == 3'h7); // R16
            irq_autovector <= auto_vector_request_s; // R15
        end
    end

    ebi_arbiter u_arb (
        .clk(clk),
        .rst_n(rst_n),
        .bus_request(br_s),
        .grant_acknowledge(grant_acknowledge_s), // R20
        .locked(lock_q),
        .bus_idle(st_q == ebi_pkg::ST_IDLE),
        .bus_grant(bus_grant),
        .bus_owned(bus_owned)
    );

    // checks
    property p_strobe_order;
        @(posedge clk) disable iff (!rst_n)
        $rose(data_strobe) |-> address_strobe && $past(address_strobe);
    endproperty
    a_strobe_order: assert property (p_strobe_order) else $error("data strobe without address"); // R9

    // address phase then data phase of one bus cycle
    sequence s_cycle_open;
        address_strobe ##1 (data_strobe && buffer_enable && !cycle_begin_pulse);
    endsequence

    property p_begin_with_as;
        @(posedge clk) disable iff (!rst_n)
        cycle_begin_pulse |-> s_cycle_open;
    endproperty
    a_begin_with_as: assert property (p_begin_with_as) else $error("cycle begin pulse wrong"); // R6

    property p_ocs_sub;
        @(posedge clk) disable iff (!rst_n)
        first_operand_cycle_pulse |-> cycle_begin_pulse;
    endproperty
    a_ocs_sub: assert property (p_ocs_sub) else $error("operand pulse without cycle"); // R7

    property p_buffer_enable;
        @(posedge clk) disable iff (!rst_n)
        buffer_enable |-> data_strobe;
    endproperty
    a_buffer_enable: assert property (p_buffer_enable) else $error("buffer enable outside data phase"); // R11

    property p_grant_hold;
        @(posedge clk) disable iff (!rst_n)
        $rose(bus_grant) |-> $past(br_s) && !$past(lock_q);
    endproperty
    a_grant_hold: assert property (p_grant_hold) else $error("grant without request"); // R18

    property p_grant_drop;
        @(posedge clk) disable iff (!rst_n)
        $rose(grant_acknowledge_s) && bus_grant |-> ##[1:3] !bus_grant;
    endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("grant not released"); // R19

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        halt_s && st_q == ebi_pkg::ST_IDLE |=> !cycle_begin_pulse;
    endproperty
    a_halt: assert property (p_halt) else $error("cycle started under halt"); // R22

    property p_cache;
        @(posedge clk) disable iff (!rst_n)
        cache_off_input_s |=> !cache_enable;
    endproperty
    a_cache: assert property (p_cache) else $error("cache on while disabled"); // R13
endmodule
`default_nettype wire

/* File: include/ebi_pkg.sv */
// constants and types for the external bus interface
`default_nettype none
package ebi_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // arbitration windows, in half clocks of the documented bus clock
    localparam int unsigned GRANT_MIN_HALF = 3;
    localparam int unsigned GRANT_MAX_HALF = 7;
    // cycles of our clock from request to grant and from acknowledge to release: ceil(1.5) and floor(3.5)
    localparam logic [2:0] GRANT_DLY = 3'((GRANT_MIN_HALF + 1) / 2);
    localparam logic [2:0] GRANT_MAX = 3'(GRANT_MAX_HALF / 2);
    localparam logic [2:0] RELEASE_DLY = 3'((GRANT_MIN_HALF + 1) / 2);
    // port width acknowledge encodings, active high here
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_8 = 2'h1;
    localparam logic [1:0] ACK_16 = 2'h2;
    localparam logic [1:0] ACK_32 = 2'h3;
    // bytes left encodings
    localparam logic [1:0] SZ_4 = 2'h0;
    localparam logic [1:0] SZ_1 = 2'h1;
    localparam logic [1:0] SZ_2 = 2'h2;
    localparam logic [1:0] SZ_3 = 2'h3;
    localparam logic [2:0] SPACE_RESET = 3'h0;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DONE} ebi_bus_t;
    typedef enum logic [1:0] {AR_OWN, AR_WAIT, AR_GRANT, AR_OFF} ebi_arb_t;
endpackage
`default_nettype wire
